// ### core/tmrb_pkg.sv
package tmrb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 16;
  localparam logic [4:0]  ADDR_COMPARE   = 5'h05;
  localparam logic [4:0]  ADDR_CONTROL   = 5'h0A;
  localparam logic [4:0]  ADDR_COUNT     = 5'h0B;
  localparam logic [4:0]  ADDR_CAPRELOAD = 5'h0C;
  localparam logic [4:0]  ADDR_IRQ_STAT  = 5'h0D;
  localparam logic [4:0]  ADDR_IRQ_MASK  = 5'h0E;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int          CTL_CAP_SEL    = 0;
  localparam int          CTL_IRQ_EN     = 1;
  localparam int          CTL_RUN        = 2;
  localparam int          CTL_EXT_EN     = 3;
  localparam int          CTL_DOWN_EN    = 4;
  localparam int          CTL_CLKOUT_EN  = 5;
  localparam int          CTL_EXT_FLAG   = 6;
  localparam int          CTL_OVF_FLAG   = 7;
  localparam int          CTL_PWM_EN     = 11;
  localparam logic [15:0] CTL_WR_MASK    = 16'h0FFF;
  localparam logic [15:0] CTL_RESET      = 16'h0000;
  localparam logic [15:0] CNT_MAX        = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] CNT_ONE        = 16'h0001;

  // ----------------------------------------------------------------
  // Event status fields
  // ----------------------------------------------------------------
  localparam int          EV_W           = 3;
  localparam int          EV_TIMER_REQ   = 0;
  localparam int          EV_CAPTURE     = 1;
  localparam int          EV_RELOAD      = 2;
  localparam logic [2:0]  EV_NONE        = 3'h0;

  typedef enum logic [1:0] {
    TMRB_DIR_UP   = 2'b01,
    TMRB_DIR_DOWN = 2'b10
  } tmrb_dir_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tmrb_bus_req_t;

endpackage

// ### core/tmrb_ctrl.sv
// Chosen here: the strobed register port.
`timescale 1ns/10ps

// Operation
// - Control register clears to zero on reset
// - Capture mode: pin falling edge captures count
// - Reload mode: reload on overflow and pin edge
// - Irq enable gates overflow and trigger flags
// - Clock output mode: overflow sets, no irq
// - Counts only while run bit set
// - Pin edge reloads count to zero, up-count
// - External enable low ignores pin events
// - PWM falling edge sets trigger, no reload
// - Down enable: pin selects count direction
// - PWM up/down direction chosen internally
// - Compare: restart, or alternate up/down
// - Overflow flag set by hardware, software clears
// - One register holds capture and reload value
// - Software set trigger flag raises irq
module tmrb_ctrl (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  input  wire tmrb_pkg::tmrb_bus_req_t bus_i,
  output logic [tmrb_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                   ext_pin_i,
  output logic                        pwm_o,
  output logic                        timer_irq_o,
  output logic                        irq_o
);
  import tmrb_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Count, registers and read-back padding are built for these widths
  if (DATA_W != 16 || EV_W != 3) begin : g_width_chk
    $error("register word must be 16 bits and status 3 bits");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       ctrl;
    logic [15:0]       count;
    logic [15:0]       cap_rel;
    logic [15:0]       compare;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic [15:0]       rdata;
    tmrb_dir_t         dir;
    logic              pin_prev;
    logic              pwm;
    logic              req_prev;
  } tmrb_state_t;

  tmrb_state_t s;
  tmrb_state_t next_s;

  function automatic logic hit(input tmrb_bus_req_t b, input logic [ADDR_W-1:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  logic cap_sel;
  logic irq_en;
  logic run;
  logic ext_en;
  logic down_en;
  logic clkout_en;
  logic pwm_mode;
  logic pin_fall;
  logic pwm_fall;
  logic timer_req;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cr;

  assign cap_sel   = s.ctrl[CTL_CAP_SEL];
  assign irq_en    = s.ctrl[CTL_IRQ_EN];
  assign run       = s.ctrl[CTL_RUN];
  assign ext_en    = s.ctrl[CTL_EXT_EN];
  assign down_en   = s.ctrl[CTL_DOWN_EN];
  assign clkout_en = s.ctrl[CTL_CLKOUT_EN];
  assign pwm_mode  = s.ctrl[CTL_PWM_EN] && !cap_sel;
  assign pin_fall  = s.pin_prev && !ext_pin_i;
  assign pwm_fall  = s.pwm && !(s.count < s.compare);
  assign wr_ctrl   = hit(bus_i, ADDR_CONTROL);
  assign wr_count  = hit(bus_i, ADDR_COUNT);
  assign wr_cr     = hit(bus_i, ADDR_CAPRELOAD);

  // Clock output mode masks the overflow flag, never the trigger flag
  assign timer_req = irq_en && ((s.ctrl[CTL_OVF_FLAG] && !clkout_en)
                     || s.ctrl[CTL_EXT_FLAG]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        ovf_ev;
    logic        ext_ev;
    logic        cap_ev;
    logic        rel_ev;
    logic [15:0] w;
    next_s = s;
    ovf_ev = 1'b0;
    ext_ev = 1'b0;
    cap_ev = 1'b0;
    rel_ev = 1'b0;
    w      = bus_i.wdata;
    next_s.pin_prev = ext_pin_i;
    next_s.pwm      = pwm_mode && (s.count < s.compare);
    next_s.req_prev = timer_req;

    // Counting, one step per clock while running
    if (run) begin
      if (cap_sel) begin
        next_s.count = s.count + CNT_ONE;
        if (s.count == CNT_MAX) begin
          ovf_ev = 1'b1;
        end
      end else if (pwm_mode) begin
        if (!down_en) begin
          if (s.count >= s.cap_rel) begin
            next_s.count = CNT_ZERO;
            ovf_ev       = 1'b1;
          end else begin
            next_s.count = s.count + CNT_ONE;
          end
        end else begin
          unique case (s.dir)
            TMRB_DIR_UP: begin
              if (s.count >= s.cap_rel) begin
                next_s.dir   = TMRB_DIR_DOWN;
                next_s.count = s.count - CNT_ONE;
              end else begin
                next_s.count = s.count + CNT_ONE;
              end
            end
            TMRB_DIR_DOWN: begin
              if (s.count == CNT_ZERO) begin
                next_s.dir   = TMRB_DIR_UP;
                next_s.count = CNT_ONE;
                ovf_ev       = 1'b1;
              end else begin
                next_s.count = s.count - CNT_ONE;
              end
            end
            default: next_s.dir = TMRB_DIR_UP;
          endcase
        end
      end else if (down_en && !ext_pin_i) begin
        if (s.count == CNT_ZERO) begin
          next_s.count = s.cap_rel;
          ovf_ev       = 1'b1;
        end else begin
          next_s.count = s.count - CNT_ONE;
        end
      end else begin
        if (s.count == CNT_MAX) begin
          next_s.count = s.cap_rel;
          ovf_ev       = 1'b1;
          rel_ev       = 1'b1;
        end else begin
          next_s.count = s.count + CNT_ONE;
        end
      end
    end

    // External pin edges: ignored unless enabled; the pin level still selects down counting
    if (ext_en) begin
      if (cap_sel && pin_fall) begin
        next_s.cap_rel = s.count;
        ext_ev         = 1'b1;
        cap_ev         = 1'b1;
      end else if (pwm_mode) begin
        ext_ev = pwm_fall;
      end else if (!cap_sel && !down_en && pin_fall) begin
        next_s.count = CNT_ZERO;
        ext_ev       = 1'b1;
        rel_ev       = 1'b1;
      end
    end

    // Software writes; a hardware flag set wins over a clear
    if (wr_ctrl) begin
      next_s.ctrl = w & CTL_WR_MASK;
    end
    next_s.ctrl[CTL_OVF_FLAG] = (wr_ctrl ? w[CTL_OVF_FLAG] : s.ctrl[CTL_OVF_FLAG])
                                || ovf_ev;
    next_s.ctrl[CTL_EXT_FLAG] = (wr_ctrl ? w[CTL_EXT_FLAG] : s.ctrl[CTL_EXT_FLAG])
                                || ext_ev;
    if (wr_count) begin
      next_s.count = w;
    end
    if (wr_cr) begin
      next_s.cap_rel = w;
    end
    if (hit(bus_i, ADDR_COMPARE)) begin
      next_s.compare = w;
    end
    if (hit(bus_i, ADDR_IRQ_MASK)) begin
      next_s.mask = w[EV_W-1:0];
    end
    next_s.status = s.status & ~(hit(bus_i, ADDR_IRQ_STAT) ? w[EV_W-1:0] : EV_NONE);
    next_s.status[EV_TIMER_REQ] = next_s.status[EV_TIMER_REQ] || (timer_req && !s.req_prev);
    next_s.status[EV_CAPTURE]   = next_s.status[EV_CAPTURE] || cap_ev;
    next_s.status[EV_RELOAD]    = next_s.status[EV_RELOAD] || rel_ev;

    // Read data stand only in the cycle after the strobe
    next_s.rdata = CNT_ZERO;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_CONTROL:   next_s.rdata = s.ctrl;
        ADDR_COUNT:     next_s.rdata = s.count;
        ADDR_CAPRELOAD: next_s.rdata = s.cap_rel;
        ADDR_COMPARE:   next_s.rdata = s.compare;
        ADDR_IRQ_STAT:  next_s.rdata = {13'h0000, s.status};
        ADDR_IRQ_MASK:  next_s.rdata = {13'h0000, s.mask};
        default:        next_s.rdata = CNT_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.ctrl     <= CTL_RESET;
      s.dir      <= TMRB_DIR_UP;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o     = s.rdata;
  assign pwm_o       = s.pwm && clkout_en;
  assign timer_irq_o = timer_req;
  assign irq_o       = |(s.status & s.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  logic quiet;
  assign quiet = !wr_ctrl && !wr_count && !wr_cr;

  reset_clear_a: assert property ($fell(rst_i) |-> s.ctrl == CTL_RESET)
    else $error("control not cleared by reset");

  capture_a: assert property (
    cap_sel && ext_en && pin_fall && quiet |=> s.cap_rel == $past(s.count))
    else $error("capture missed");

  ovf_reload_a: assert property (
    run && !cap_sel && !pwm_mode && !down_en && s.count == CNT_MAX
    && !(ext_en && pin_fall) && quiet
    |=> s.count == $past(s.cap_rel) && s.ctrl[CTL_OVF_FLAG])
    else $error("overflow reload wrong");

  clkout_noirq_a: assert property (
    s.ctrl[CTL_CLKOUT_EN] && !s.ctrl[CTL_EXT_FLAG] |-> !timer_irq_o)
    else $error("irq in clock output mode");

  irq_gate_a: assert property (
    !irq_en |-> !timer_irq_o)
    else $error("irq while disabled");

  run_hold_a: assert property (
    !run && quiet && !ext_en |=> $stable(s.count))
    else $error("count moved while halted");

  ext_reload_a: assert property (
    ext_en && pin_fall && !cap_sel && !pwm_mode && !down_en && quiet
    |=> s.count == CNT_ZERO && s.ctrl[CTL_EXT_FLAG])
    else $error("external reload wrong");

  ext_ignore_a: assert property (
    !ext_en && !wr_cr && !wr_ctrl |=> $stable(s.cap_rel) && !$rose(s.ctrl[CTL_EXT_FLAG]))
    else $error("pin event not ignored");

  up_step_a: assert property (
    run && !cap_sel && !pwm_mode && !down_en && s.count != CNT_MAX
    && !(ext_en && pin_fall) && quiet |=> s.count == $past(s.count) + CNT_ONE)
    else $error("up count step wrong");

  down_step_a: assert property (
    run && !cap_sel && !pwm_mode && down_en && !ext_pin_i && s.count != CNT_ZERO
    && quiet |=> s.count == $past(s.count) - CNT_ONE)
    else $error("down count step wrong");

  ovf_sticky_a: assert property (
    s.ctrl[CTL_OVF_FLAG] && !wr_ctrl |=> s.ctrl[CTL_OVF_FLAG] [*1])
    else $error("overflow flag lost");

  pwm_flag_a: assert property (
    pwm_mode && ext_en && pwm_fall && quiet |=> s.ctrl[CTL_EXT_FLAG])
    else $error("pwm edge flag missed");

  // PWM checks exclude software writes, which win over counting
  pwm_noreload_a: assert property (
    run && pwm_mode && !down_en && ext_en && (pin_fall || pwm_fall)
    && s.count < s.cap_rel && quiet |=> s.count == $past(s.count) + CNT_ONE)
    else $error("pwm edge caused reload");

  pwm_limit_a: assert property (
    run && pwm_mode && !down_en && s.count >= s.cap_rel && quiet
    |=> s.count == CNT_ZERO && s.ctrl[CTL_OVF_FLAG])
    else $error("pwm restart wrong");

  updown_turn_a: assert property (
    run && pwm_mode && down_en && s.dir == TMRB_DIR_UP && s.count >= s.cap_rel
    && quiet |=> s.dir == TMRB_DIR_DOWN && s.count == $past(s.count) - CNT_ONE)
    else $error("pwm turn at top wrong");

  updown_floor_a: assert property (
    run && pwm_mode && down_en && s.dir == TMRB_DIR_DOWN && s.count == CNT_ZERO
    && quiet |=> s.dir == TMRB_DIR_UP && s.count == CNT_ONE && s.ctrl[CTL_OVF_FLAG])
    else $error("pwm turn at zero wrong");

  ovf_irq_a: assert property (
    irq_en && s.ctrl[CTL_OVF_FLAG] && !clkout_en |-> timer_irq_o)
    else $error("overflow irq missing");

  soft_irq_a: assert property (
    irq_en && s.ctrl[CTL_EXT_FLAG] |-> timer_irq_o)
    else $error("trigger flag irq missing");

  ext_sticky_a: assert property (
    s.ctrl[CTL_EXT_FLAG] && !wr_ctrl |=> s.ctrl[CTL_EXT_FLAG])
    else $error("trigger flag lost");

  cap_cover_c: cover property (cap_sel && ext_en && pin_fall);
  pwm_cover_c: cover property (pwm_mode && ext_en && pwm_fall);
  updown_cover_c: cover property (pwm_mode && down_en && s.dir == TMRB_DIR_DOWN);
  ovf_cover_c: cover property (run && $rose(s.ctrl[CTL_OVF_FLAG]));
  irq_cover_c: cover property ($rose(irq_o));

endmodule

// ### sim/tmrb_pin_model.sv
`timescale 1ns/10ps

// --------------------------------------------
// External trigger and direction source
// --------------------------------------------
module tmrb_pin_model (
  input  wire logic mclk_i,
  output logic      ext_pin_o
);
  initial ext_pin_o = 1'b1;

  // Direction level, changed just after an edge
  task automatic set_level(input logic lvl);
    @(posedge mclk_i);
    ext_pin_o <= lvl;
  endtask

  // High then low: one clean negative transition
  task automatic fall();
    @(posedge mclk_i);
    ext_pin_o <= 1'b1;
    repeat (2) @(posedge mclk_i);
    ext_pin_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule

// ### sim/timer_b_control_logic_tb.sv
`timescale 1ns/10ps

module timer_b_control_logic_tb;
  import tmrb_pkg::*;

  logic          mclk_i = 1'b0;
  logic          rst_i  = 1'b1;
  tmrb_bus_req_t bus    = '0;
  logic [15:0]   rdata;
  logic          ext_pin;
  logic          pwm;
  logic          timer_irq;
  logic          irq;
  logic [15:0]   a;
  logic [15:0]   b;
  int            err_total = 0;
  int            checked   = 0;

  always #50 mclk_i = ~mclk_i;

  tmrb_ctrl tmrb_ctrl_i (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .bus_i       (bus),
    .rdata_o     (rdata),
    .ext_pin_i   (ext_pin),
    .pwm_o       (pwm),
    .timer_irq_o (timer_irq),
    .irq_o       (irq)
  );

  tmrb_pin_model tmrb_pin_model_i (
    .mclk_i    (mclk_i),
    .ext_pin_o (ext_pin)
  );

  // --------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [15:0] d);
    @(posedge mclk_i);
    bus.wr    <= 1'b1;
    bus.addr  <= ad;
    bus.wdata <= d;
    @(posedge mclk_i);
    bus.wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [15:0] d);
    @(posedge mclk_i);
    bus.rd   <= 1'b1;
    bus.addr <= ad;
    @(posedge mclk_i);
    bus.rd   <= 1'b0;
    @(negedge mclk_i);
    d = rdata;
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    rst_i <= 1'b0;
  endtask

  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_reset();
    do_reset(16);
    rd(ADDR_CONTROL, a); chk(a, 16'h0000);
    wr(ADDR_CONTROL, 16'h0F3C);
    do_reset(2);
    rd(ADDR_CONTROL, a); chk(a, 16'h0000);
    wr(ADDR_CONTROL, 16'hF000);
    rd(ADDR_CONTROL, a); chk(a, 16'h0000);
    rd(5'h1F, a); chk(a, 16'h0000);
  endtask

  // Back-to-back reads are taken two edges apart
  task automatic t_run_halt();
    wr(ADDR_CONTROL, 16'h0004);
    rd(ADDR_COUNT, a); rd(ADDR_COUNT, b); chk(b, a + 16'h0002);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_COUNT, a); rd(ADDR_COUNT, b); chk(b, a);
  endtask

  task automatic t_down();
    tmrb_pin_model_i.set_level(1'b0);
    wr(ADDR_COUNT, 16'h0100);
    wr(ADDR_CONTROL, 16'h0014);
    rd(ADDR_COUNT, a); rd(ADDR_COUNT, b); chk(b, a - 16'h0002);
    wr(ADDR_CONTROL, 16'h0004);
    rd(ADDR_COUNT, a); rd(ADDR_COUNT, b); chk(b, a + 16'h0002);
    wr(ADDR_CONTROL, 16'h0000);
    tmrb_pin_model_i.set_level(1'b1);
  endtask

  task automatic t_overflow();
    int i;
    wr(ADDR_CAPRELOAD, 16'hFFF0);
    wr(ADDR_COUNT, 16'hFFFD);
    wr(ADDR_CONTROL, 16'h0006);
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(timer_irq, 1'b1);
    rd(ADDR_CONTROL, a); chk(a, 16'h0086);
    rd(ADDR_COUNT, a); chk(a >= 16'hFFF0, 1'b1);
    // Clock output mode: flag still sets, request stays low
    wr(ADDR_CONTROL, 16'h0026);
    for (i = 0; i < 24; i++) begin
      @(negedge mclk_i);
      chk(timer_irq, 1'b0);
    end
    rd(ADDR_CONTROL, a); chk(a, 16'h00A6);
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_CONTROL, a); chk(a, 16'h0000);
    rd(ADDR_IRQ_STAT, a); chk(a, 16'h0005);
    wr(ADDR_IRQ_MASK, 16'h0004);
    @(negedge mclk_i); chk(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 16'h0002);
    @(negedge mclk_i); chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0004);
    wr(ADDR_IRQ_STAT, 16'h0007);
    @(negedge mclk_i); chk(irq, 1'b0);
    rd(ADDR_IRQ_STAT, a); chk(a, 16'h0000);
  endtask

  // Capture while stopped keeps the expected value exact
  task automatic t_capture();
    wr(ADDR_CONTROL, 16'h0009);
    wr(ADDR_COUNT, 16'h1234);
    tmrb_pin_model_i.fall();
    rd(ADDR_CAPRELOAD, a); chk(a, 16'h1234);
    rd(ADDR_IRQ_STAT, a); chk(a[1], 1'b1);
    wr(ADDR_CONTROL, 16'h0001);
    wr(ADDR_COUNT, 16'h5678);
    tmrb_pin_model_i.fall();
    rd(ADDR_CAPRELOAD, a); chk(a, 16'h1234);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_COUNT, 16'h0055);
    tmrb_pin_model_i.fall();
    rd(ADDR_COUNT, a); chk(a, 16'h0055);
  endtask

  task automatic t_reload();
    wr(ADDR_CONTROL, 16'h0008);
    wr(ADDR_COUNT, 16'h0055);
    tmrb_pin_model_i.fall();
    rd(ADDR_COUNT, a); chk(a, 16'h0000);
    rd(ADDR_CONTROL, a); chk(a, 16'h0048);
    @(negedge mclk_i); chk(timer_irq, 1'b0);
    wr(ADDR_CONTROL, 16'h0000);
  endtask

  task automatic t_soft_flag();
    wr(ADDR_CONTROL, 16'h0042);
    @(negedge mclk_i); chk(timer_irq, 1'b1);
    wr(ADDR_CONTROL, 16'h0040);
    @(negedge mclk_i); chk(timer_irq, 1'b0);
    wr(ADDR_CONTROL, 16'h0000);
  endtask

  // Reload 7, compare 3: eight counts up, or fourteen up and down
  task automatic t_pwm();
    int i;
    int hi;
    wr(ADDR_CAPRELOAD, 16'h0007);
    wr(ADDR_COMPARE, 16'h0003);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CONTROL, 16'h082C);
    tmrb_pin_model_i.fall();
    hi = 0;
    for (i = 0; i < 8; i++) begin
      @(negedge mclk_i);
      hi += pwm;
    end
    chk(16'(hi), 16'h0003);
    rd(ADDR_CONTROL, a); chk(a, 16'h08EC);
    // Pin stays low: the direction must come from the count alone
    wr(ADDR_CONTROL, 16'h083C);
    hi = 0;
    for (i = 0; i < 14; i++) begin
      @(negedge mclk_i);
      hi += pwm;
    end
    chk(16'(hi), 16'h0005);
    rd(ADDR_COUNT, a); chk(a <= 16'h0007, 1'b1);
    wr(ADDR_CONTROL, 16'h0000);
  endtask

  // --------------------------------------------
  // Sequence and verdict
  // --------------------------------------------
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare stays off while capturing; sequence never combines them
  initial begin
    t_reset();
    t_run_halt();
    t_down();
    t_overflow();
    t_capture();
    t_reload();
    t_soft_flag();
    t_pwm();
    finish_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    finish_test();
  end
endmodule
